// File: rtl/asce_ctrl.sv
// converter status flags, sample timer, scan tracking and comparator enables
// assumes an AHB-Lite master on mclk; converter core strobes share mclk,
// analog reference status arrives asynchronously on pins
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module asce_ctrl (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // analog reference status pins
  input  wire logic        bandgapRdyPin,
  input  wire logic        vrefRdyPin,
  input  wire logic        refFaultPin,
  // converter core strobes
  input  wire logic        scanStart,
  input  wire logic        convDone,
  input  wire logic [5:0]  convChan,
  input  wire logic        cmpTrue,
  input  wire logic        sampleStart,
  // outputs to the analog side and core
  output logic             moduleOn,
  output logic [2:0]       capSelect,
  output logic             tadTick,
  output logic             sampling,
  output logic             cmpAccept,
  output logic             irq
);

  // registers
  logic [31:0] ctrlOne_r, ctrlTwo_r, cmpEn_r, cmpCtrl_r, scanLo_r, scanHi_r;
  logic [asce_pkg::IRQ_W-1:0] irqStat_r, irqMask_r;
  logic        refReady_r, refFault_r, scanDone_r, cmpEvent_r;
  logic [63:0] scanPend_r;
  logic        scanBusy_r;
  logic [7:0]  tadCnt_r;
  logic [10:0] smpCnt_r;
  asce_pkg::asce_smp_t smpState_r;
  logic        refReadyDly_r, refFaultDly_r, scanDoneDly_r, cmpEventDly_r;
  // synchronisers
  logic [1:0]  bgSync_r, vrSync_r, flSync_r;
  // bus pipeline
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r, hresp_r, irq_r, tadTick_r, sampling_r, cmpAccept_r;

  logic        addrTake, rdTake, bandRefOk, modOn, cmpOn, smpGo;
  logic [7:0]  tadLen;
  logic [31:0] ctrlTwoView;

  // true when a captured address hits a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // conversion clock length in mclk periods: 1 at zero, else twice the code
  function automatic logic [7:0] tadLength(input logic [6:0] dv);
    tadLength = (dv == 7'h00) ? 8'h01 : {dv, 1'b0};
  endfunction : tadLength

  assign addrTake    = hsel & htrans[1] & hready;
  assign rdTake      = addrTake & ~hwrite;
  assign modOn       = ctrlOne_r[asce_pkg::MOD_ON_BIT];
  assign cmpOn       = cmpCtrl_r[asce_pkg::CMP_EN_BIT];
  assign bandRefOk   = bgSync_r[1] & vrSync_r[1];
  assign tadLen      = tadLength(ctrlTwo_r[asce_pkg::DIV_W-1:0]);
  // ready reads zero even in the cycle the module switches off
  assign ctrlTwoView = {refReady_r & modOn, refFault_r, scanDone_r, ctrlTwo_r[28:0]};
  // a sample window opens only from idle with the module on
  assign smpGo       = (smpState_r == asce_pkg::SMP_IDLE) & sampleStart & modOn;

  // two-flop synchronisers for the asynchronous reference pins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bgSync_r <= 2'h0;
      vrSync_r <= 2'h0;
      flSync_r <= 2'h0;
    end else begin
      bgSync_r <= {bgSync_r[0], bandgapRdyPin};
      vrSync_r <= {vrSync_r[0], vrefRdyPin};
      flSync_r <= {flSync_r[0], refFaultPin};
    end
  end

  // zero-wait slave: read data prepared at the address phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPend_r    <= 1'b0;
      wrAddr_r    <= 8'h00;
      hrdata_r    <= asce_pkg::REG_RST;
      hreadyout_r <= 1'b0;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      wrPend_r    <= addrTake & hwrite;
      wrAddr_r    <= haddr[7:0];
      if (rdTake) begin
        if (hit(haddr[7:0], asce_pkg::OFS_CTRL_ONE))      hrdata_r <= ctrlOne_r;
        else if (hit(haddr[7:0], asce_pkg::OFS_CTRL_TWO)) hrdata_r <= ctrlTwoView;
        else if (hit(haddr[7:0], asce_pkg::OFS_CMP_EN))   hrdata_r <= cmpEn_r;
        else if (hit(haddr[7:0], asce_pkg::OFS_CMP_CTRL)) hrdata_r <= {cmpCtrl_r[31:6], cmpEvent_r, cmpCtrl_r[4:0]};
        else if (hit(haddr[7:0], asce_pkg::OFS_SCAN_LO))  hrdata_r <= scanLo_r;
        else if (hit(haddr[7:0], asce_pkg::OFS_SCAN_HI))  hrdata_r <= scanHi_r;
        else if (hit(haddr[7:0], asce_pkg::OFS_IRQ_STAT)) hrdata_r <= {28'h0000000, irqStat_r};
        else if (hit(haddr[7:0], asce_pkg::OFS_IRQ_MASK)) hrdata_r <= {28'h0000000, irqMask_r};
        else hrdata_r <= 32'h0000_0000; // unmapped reads return zero
      end
    end
  end

  // software-written control registers; status bits are not stored here
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrlOne_r <= asce_pkg::REG_RST;
      ctrlTwo_r <= asce_pkg::REG_RST;
      cmpEn_r   <= asce_pkg::REG_RST;
      cmpCtrl_r <= asce_pkg::REG_RST;
      scanLo_r  <= asce_pkg::REG_RST;
      scanHi_r  <= asce_pkg::REG_RST;
      irqMask_r <= asce_pkg::IRQ_RST;
    end else if (wrPend_r) begin
      if (hit(wrAddr_r, asce_pkg::OFS_CTRL_ONE))
        ctrlOne_r <= hwdata & (32'h1 << asce_pkg::MOD_ON_BIT);
      if (hit(wrAddr_r, asce_pkg::OFS_CTRL_TWO))
        ctrlTwo_r <= hwdata & asce_pkg::CTRL_TWO_WMASK;
      // per-input enable word, no write lock in hardware
      if (hit(wrAddr_r, asce_pkg::OFS_CMP_EN))
        cmpEn_r <= hwdata;
      if (hit(wrAddr_r, asce_pkg::OFS_CMP_CTRL))
        cmpCtrl_r <= hwdata & asce_pkg::CMP_CTRL_WMASK;
      if (hit(wrAddr_r, asce_pkg::OFS_SCAN_LO))
        scanLo_r <= hwdata;
      if (hit(wrAddr_r, asce_pkg::OFS_SCAN_HI))
        scanHi_r <= hwdata;
      if (hit(wrAddr_r, asce_pkg::OFS_IRQ_MASK))
        irqMask_r <= hwdata[asce_pkg::IRQ_W-1:0];
    end
  end

  // reference ready and fault flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refReady_r <= 1'b0;
      refFault_r <= 1'b0;
    end else begin
      refReady_r <= bandRefOk & modOn;
      if (flSync_r[1] & modOn)
        refFault_r <= 1'b1;
      // clear needs off plus raw readiness
      else if (~modOn & bandRefOk)
        refFault_r <= 1'b0;
    end
  end

  // scan tracking: pending mask loaded at scan start, emptied by conversions
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scanPend_r <= 64'h0;
      scanBusy_r <= 1'b0;
      scanDone_r <= 1'b0;
    end else begin
      if (scanStart) begin
        scanPend_r <= {scanHi_r, scanLo_r};
        scanBusy_r <= 1'b1;
      end else if (scanBusy_r) begin
        if (convDone)
          scanPend_r[convChan] <= 1'b0;
        if (scanPend_r == 64'h0)
          scanBusy_r <= 1'b0;
      end
      // completion wins over a read in the same cycle
      if (scanBusy_r & ~scanStart & (scanPend_r == 64'h0))
        scanDone_r <= 1'b1;
      else if (scanStart | (rdTake & hit(haddr[7:0], asce_pkg::OFS_CTRL_TWO)))
        scanDone_r <= 1'b0;
    end
  end

  // conversion clock divider, free running while the module is on
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tadCnt_r  <= 8'h00;
      tadTick_r <= 1'b0;
    end else begin
      // restart on sample start, so the window holds whole periods
      if (smpGo) begin
        tadCnt_r  <= (tadLen == 8'h01) ? 8'h00 : 8'h01;
        tadTick_r <= (tadLen == 8'h01);
      end else if (~modOn || tadCnt_r >= tadLen - 8'h01) begin
        tadCnt_r  <= 8'h00;
        tadTick_r <= modOn;
      end else begin
        tadCnt_r  <= tadCnt_r + 8'h01;
        tadTick_r <= 1'b0;
      end
    end
  end

  // sample window counted in conversion clock periods
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      smpState_r <= asce_pkg::SMP_IDLE;
      smpCnt_r   <= 11'h000;
      sampling_r <= 1'b0;
    end else begin
      case (smpState_r)
        asce_pkg::SMP_IDLE: begin
          smpCnt_r <= 11'h000;
          if (sampleStart & modOn) begin
            smpState_r <= asce_pkg::SMP_RUN;
            sampling_r <= 1'b1;
          end
        end
        asce_pkg::SMP_RUN: begin
          if (~modOn) begin
            smpState_r <= asce_pkg::SMP_IDLE;
            sampling_r <= 1'b0;
          end else if (tadTick_r) begin
            if (smpCnt_r + 11'h001 >= {1'b0, ctrlTwo_r[25:16]} + asce_pkg::SAMC_EXTRA) begin
              smpState_r <= asce_pkg::SMP_IDLE;
              sampling_r <= 1'b0;
            end
            smpCnt_r <= smpCnt_r + 11'h001;
          end
        end
        default: begin
          smpState_r <= asce_pkg::SMP_IDLE;
          sampling_r <= 1'b0;
        end
      endcase
    end
  end

  // comparator input gating and event flag
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmpEvent_r  <= 1'b0;
      cmpAccept_r <= 1'b0;
    end else begin
      // only inputs 0..31 reach the comparator
      cmpAccept_r <= cmpOn & convDone & ~convChan[5] & cmpEn_r[convChan[4:0]];
      if (~cmpOn)
        cmpEvent_r <= 1'b0;
      else if (cmpAccept_r & cmpTrue)
        cmpEvent_r <= 1'b1;
    end
  end

  // interrupt status: rising edges of flags, write one to clear, set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refReadyDly_r <= 1'b0;
      refFaultDly_r <= 1'b0;
      scanDoneDly_r <= 1'b0;
      cmpEventDly_r <= 1'b0;
      irqStat_r     <= asce_pkg::IRQ_RST;
      irq_r         <= 1'b0;
    end else begin
      refReadyDly_r <= refReady_r;
      refFaultDly_r <= refFault_r;
      scanDoneDly_r <= scanDone_r;
      cmpEventDly_r <= cmpEvent_r;
      irqStat_r <= (irqStat_r & ~((wrPend_r & hit(wrAddr_r, asce_pkg::OFS_IRQ_STAT))
                                  ? hwdata[asce_pkg::IRQ_W-1:0] : 4'h0))
                 // ready event only with its enable
                 | {cmpEvent_r & ~cmpEventDly_r & cmpCtrl_r[asce_pkg::CMP_GIEN_BIT],
                    scanDone_r & ~scanDoneDly_r & ctrlTwo_r[asce_pkg::EOS_IEN_BIT],
                    refFault_r & ~refFaultDly_r & ctrlTwo_r[asce_pkg::FLT_IEN_BIT],
                    refReady_r & ~refReadyDly_r & ctrlTwo_r[asce_pkg::RDY_IEN_BIT]};
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  // outputs straight from flops
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign moduleOn  = ctrlOne_r[asce_pkg::MOD_ON_BIT];
  // code drives the capacitor ladder, step 2.5 pF
  assign capSelect = ctrlTwo_r[asce_pkg::CAP_LSB +: asce_pkg::CAP_W];
  assign tadTick   = tadTick_r;
  assign sampling  = sampling_r;
  assign cmpAccept = cmpAccept_r;
  assign irq       = irq_r;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_startSample;
    (smpState_r == asce_pkg::SMP_IDLE) && sampleStart && modOn;
  endsequence
  sequence s_sampleOn;
    sampling_r [*2];
  endsequence

  chk_ready_needs_refs: assert property (refReady_r |-> $past(bandRefOk))
    else $error("ready flag without both references");
  chk_ready_off_zero: assert property ($past(~modOn) |-> ~refReady_r)
    else $error("ready flag set while module off");
  chk_fault_set_on: assert property ($rose(refFault_r) |-> $past(modOn) && $past(flSync_r[1]))
    else $error("fault flag rose without fault while on");
  chk_fault_clear_cond: assert property ($fell(refFault_r) |-> $past(~modOn) && $past(bandRefOk))
    else $error("fault flag cleared under wrong condition");
  chk_scan_done_set: assert property ($rose(scanDone_r) |-> $past(scanPend_r) == 64'h0)
    else $error("scan done with inputs pending");
  chk_scan_read_clear: assert property (
    rdTake && hit(haddr[7:0], asce_pkg::OFS_CTRL_TWO) && ~(scanBusy_r && scanPend_r == 64'h0)
    |=> ~scanDone_r)
    else $error("scan done survived control two read");
  chk_sample_min_len: assert property (s_startSample |=> s_sampleOn)
    else $error("sample window shorter than two cycles");
  chk_tick_spacing: assert property ($rose(tadTick_r) && ctrlTwo_r[6:0] == 7'h02 && $stable(ctrlTwo_r)
    |=> ~tadTick_r [*3])
    else $error("conversion clock ticks too close");
  chk_ready_irq_gate: assert property ($rose(irqStat_r[asce_pkg::IRQ_READY]) |->
    $past(ctrlTwo_r[asce_pkg::RDY_IEN_BIT]) && $past(refReady_r))
    else $error("ready interrupt without enable");
  chk_cmp_gate: assert property (cmpAccept_r |-> $past(cmpEn_r[convChan[4:0]]) && $past(~convChan[5]))
    else $error("comparator took a disabled input");
  chk_cmp_off_clear: assert property (~cmpOn |=> ~cmpEvent_r)
    else $error("event flag kept while comparator off");

endmodule : asce_ctrl

// File: rtl/asce_pkg.sv
// constants and types for the converter status and comparator-enable block
// assumes one 25 MHz clock and an AHB-Lite slave at the offsets below
package asce_pkg;

  // register offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_CMP_EN   = 8'h08;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h0c;
  localparam logic [7:0] OFS_SCAN_LO  = 8'h10;
  localparam logic [7:0] OFS_SCAN_HI  = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // control one
  localparam int MOD_ON_BIT = 15;

  // control two field layout
  localparam int REF_READY_BIT = 31;
  localparam int REF_FAULT_BIT = 30;
  localparam int SCAN_DONE_BIT = 29;
  localparam int CAP_LSB       = 26;
  localparam int CAP_W         = 3;
  localparam int SAMC_LSB      = 16;
  localparam int SAMC_W        = 10;
  localparam int RDY_IEN_BIT   = 15;
  localparam int FLT_IEN_BIT   = 14;
  localparam int EOS_IEN_BIT   = 13;
  localparam int DIV_W         = 7;
  localparam logic [31:0] CTRL_TWO_WMASK = 32'h1fff_f77f;

  // comparator control
  localparam int CMP_EN_BIT   = 7;
  localparam int CMP_GIEN_BIT = 6;
  localparam int CMP_EVT_BIT  = 5;
  localparam logic [31:0] CMP_CTRL_WMASK = 32'h0000_00c0;

  // reset values
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  localparam logic [3:0]  IRQ_RST  = 4'h0;

  // capacitor step in tenths of a picofarad, sample time offset in periods
  localparam int CAP_STEP_TENTH_PF = 25;
  localparam logic [10:0] SAMC_EXTRA = 11'h002;
  localparam int CMP_INPUTS = 32;

  // interrupt status bit positions
  localparam int IRQ_W     = 4;
  localparam int IRQ_READY = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_SCAN  = 2;
  localparam int IRQ_CMP   = 3;

  typedef enum logic {SMP_IDLE, SMP_RUN} asce_smp_t;

endpackage : asce_pkg

// File: test/asce_ctrl_tb.sv
// self-checking bench for the converter status and comparator-enable block
// assumes asce_ctrl alone on a single AHB-Lite bus, one 25 MHz clock
`timescale 1ns/100ps
module asce_ctrl_tb;
  logic        mclk, nrst, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, capSelect;
  logic        hreadyout, hresp, bandgapRdyPin, vrefRdyPin, refFaultPin;
  logic        scanStart, convDone, cmpTrue, sampleStart;
  logic [5:0]  convChan;
  logic        moduleOn, tadTick, sampling, cmpAccept, irq;
  int          badCount, comparisons, n, m;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  asce_ctrl uut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bandgapRdyPin(bandgapRdyPin),
    .vrefRdyPin(vrefRdyPin), .refFaultPin(refFaultPin), .scanStart(scanStart),
    .convDone(convDone), .convChan(convChan), .cmpTrue(cmpTrue), .sampleStart(sampleStart),
    .moduleOn(moduleOn), .capSelect(capSelect), .tadTick(tadTick), .sampling(sampling),
    .cmpAccept(cmpAccept), .irq(irq));

  // clock source
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic conclude;
    if (badCount == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one single transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdc

  // pins pass a two-flop synchroniser, so allow it to settle
  task automatic pins(input logic b, input logic v, input logic f);
    @(posedge mclk);
    bandgapRdyPin <= b;
    vrefRdyPin    <= v;
    refFaultPin   <= f;
    repeat (6) @(posedge mclk);
  endtask : pins

  // conversion done strobe; acceptance shows one cycle later
  task automatic conv(input logic [5:0] c, output logic acc);
    @(posedge mclk);
    convDone <= 1'b1;
    convChan <= c;
    @(posedge mclk);
    convDone <= 1'b0;
    #1 acc = cmpAccept;
  endtask : conv

  task automatic strobe(input int which);
    @(posedge mclk);
    if (which == 0) scanStart <= 1'b1; else sampleStart <= 1'b1;
    @(posedge mclk);
    scanStart   <= 1'b0;
    sampleStart <= 1'b0;
  endtask : strobe

  // watchdog, far beyond the expected run
  initial begin
    #(40 * 20000);
    badCount++;
    conclude();
  end

  // main sequence
  initial begin
    logic [5:0]  chans [4] = '{6'h00, 6'h01, 6'h1f, 6'h20};
    logic        accs  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0] smp   [2] = '{32'h0000_0000, 32'h0003_0002};
    int          lens  [2] = '{2, 20};
    int          ticks [2] = '{2, 5};
    logic        a;
    badCount = 0; comparisons = 0;
    nrst = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; bandgapRdyPin = 1'b0; vrefRdyPin = 1'b0;
    refFaultPin = 1'b0; scanStart = 1'b0; convDone = 1'b0; convChan = 6'h00;
    cmpTrue = 1'b0; sampleStart = 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // reset values, write masks, unmapped place
    rdc(asce_pkg::OFS_CTRL_TWO, asce_pkg::REG_RST);
    rdc(asce_pkg::OFS_CMP_EN, asce_pkg::REG_RST);
    wr(asce_pkg::OFS_CTRL_TWO, 32'hffff_ffff);
    rdc(asce_pkg::OFS_CTRL_TWO, asce_pkg::CTRL_TWO_WMASK);
    chk({29'h0, capSelect}, 32'h0000_0007);
    wr(asce_pkg::OFS_CTRL_TWO, 32'h1400_0000);
    @(negedge mclk);
    chk({29'h0, capSelect}, 32'h0000_0005);
    wr(8'h20, 32'hffff_ffff);
    rdc(8'h20, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0);
    // ready flag held low while off, set only with both references
    wr(asce_pkg::OFS_CTRL_TWO, 32'h0000_8000);
    wr(asce_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    pins(1'b1, 1'b1, 1'b0);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_8000);
    wr(asce_pkg::OFS_CTRL_ONE, 32'h0000_8000);
    repeat (6) @(posedge mclk);
    chk({31'h0, moduleOn}, 32'h1);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h8000_8000);
    rdc(asce_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    wr(asce_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_8000);
    // enable off: the next rise raises nothing
    wr(asce_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    pins(1'b1, 1'b1, 1'b0);
    rdc(asce_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    // fault sticks while on; clears only when off and ready together
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b1, 1'b1, 1'b0);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'hc000_0000);
    wr(asce_pkg::OFS_CTRL_ONE, 32'h0000_0000);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    wr(asce_pkg::OFS_CTRL_ONE, 32'h0000_8000);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    wr(asce_pkg::OFS_CTRL_ONE, 32'h0000_0000);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h4000_0000);
    pins(1'b1, 1'b1, 1'b0);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    // scan of inputs 0 and 2, then clear on read
    wr(asce_pkg::OFS_SCAN_LO, 32'h0000_0005);
    strobe(0);
    conv(6'h00, a);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    conv(6'h02, a);
    repeat (3) @(posedge mclk);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h2000_0000);
    rdc(asce_pkg::OFS_CTRL_TWO, 32'h0000_0000);
    // comparator input enables, edges of the input range
    wr(asce_pkg::OFS_CMP_EN, 32'h8000_0001);
    wr(asce_pkg::OFS_CMP_CTRL, 32'h0000_0080);
    cmpTrue <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      conv(chans[i], a);
      chk({31'h0, a}, {31'h0, accs[i]});
    end
    rdc(asce_pkg::OFS_CMP_CTRL, 32'h0000_00a0);
    wr(asce_pkg::OFS_CMP_CTRL, 32'h0000_0000);
    rdc(asce_pkg::OFS_CMP_CTRL, 32'h0000_0000);
    cmpTrue <= 1'b0;
    // sample window length in clocks for two divider settings
    wr(asce_pkg::OFS_CTRL_ONE, 32'h0000_8000);
    for (int i = 0; i < 2; i++) begin
      wr(asce_pkg::OFS_CTRL_TWO, smp[i]);
      strobe(1);
      n = 0;
      m = 0;
      repeat (200) begin
        @(negedge mclk);
        if (sampling === 1'b1) n++;
        if (sampling === 1'b1 && tadTick === 1'b1) m++;
      end
      chk(n, lens[i]);
      chk(m, ticks[i]);
    end
    conclude();
  end
endmodule : asce_ctrl_tb
